// ===== hdl/gmp_cfg.svh
// register offsets, reset values and bus response codes for the masked gpio port
`ifndef GMP_CFG_SVH
`define GMP_CFG_SVH
`define GMP_PIN_COUNT 8
`define GMP_ADDR_WIDTH 12
`define GMP_DATA_BASE 12'h000
`define GMP_DATA_TOP 12'h3FC
`define GMP_MASK_LSB 2
`define GMP_MASK_MSB 9
`define GMP_DIR_OFFSET 12'h400
`define GMP_PID1_OFFSET 12'hFE4
`define GMP_PID2_OFFSET 12'hFE8
`define GMP_PID3_OFFSET 12'hFEC
`define GMP_CID0_OFFSET 12'hFF0
`define GMP_CID1_OFFSET 12'hFF4
`define GMP_CID2_OFFSET 12'hFF8
`define GMP_CID3_OFFSET 12'hFFC
`define GMP_VALUE_RESET 8'h00
`define GMP_DIR_RESET 8'h00
`define GMP_RESP_OKAY 2'h0
`define GMP_RESP_SLVERR 2'h2
`endif

// ===== hdl/gmp_pkg.sv
// types shared by the masked gpio port
package gmp_pkg;
    // write address and data as taken from the bus
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } gmp_wreq_t;
    // read answer
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } gmp_rresp_t;
endpackage

// ===== hdl/gmp_port.sv
// eight-pin gpio port with address-masked data register, axi4-lite slave
//
// Behaviour
// - output pins drive stored pin value bits
// - write changes only address-unmasked bits
// - read returns zero in masked bits
// - unmasked read: output stored, input live
// - reset clears pin value register
// - data register aliased over 256 words
// - writes affect only unmasked output pins
// - bits 31:8 reserved, read zero
// - three read-only peripheral identification registers
// - four read-only component identification byte registers
// - direction register, one means output
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "gmp_cfg.svh"
module gmp_port #(
    parameter logic [7:0] PID1_VALUE = 8'h11, // arbitrary identification value
    parameter logic [7:0] PID2_VALUE = 8'h22, // arbitrary identification value
    parameter logic [7:0] PID3_VALUE = 8'h33, // arbitrary identification value
    parameter logic [7:0] CID0_VALUE = 8'h44, // arbitrary identification value
    parameter logic [7:0] CID1_VALUE = 8'h55, // arbitrary identification value
    parameter logic [7:0] CID2_VALUE = 8'h66, // arbitrary identification value
    parameter logic [7:0] CID3_VALUE = 8'h77 // arbitrary identification value
) (
    input wire logic aclk, // bus clock, 50 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [11:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [11:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [7:0] pin_in, // pin levels from pads, asynchronous
    output logic [7:0] pin_out, // pin drive value
    output logic [7:0] pin_oe // pin output enable, high drives
);
    import gmp_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] value_reg; // stored pin values
    logic [7:0] dir_reg; // direction, one is output
    logic [7:0] pin_meta_reg; // first synchroniser stage
    logic [7:0] pin_sync_reg; // second synchroniser stage
    gmp_wreq_t wreq_reg; // captured write request
    logic aw_held_reg; // write address captured
    logic w_held_reg; // write data captured
    logic [7:0] rd_mask; // mask from read address
    logic [7:0] wr_mask; // mask from write address
    logic [7:0] live_value; // readback per bit
    gmp_rresp_t rd_next; // decoded read answer
    logic wr_fire; // both write halves present

    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    // two flops before any logic looks at the pads
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end
        else
        begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // write channel capture
    // ------------------------------------------------------------
    // address and data may come in either order; each is held once taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            wreq_reg <= '0;
        end
        else if (wr_fire)
        begin
            // both consumed by the write
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
        end
        else
        begin
            // take address
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                wreq_reg.addr <= s_axi_awaddr;
            end
            // take data
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wreq_reg.data <= s_axi_wdata;
                wreq_reg.strb <= s_axi_wstrb;
            end
        end
    end

    // a pending answer blocks a second fire until the master has taken it
    // so one write at most is ever in flight
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    // address bits 9:2 form the per-bit mask
    assign wr_mask = wreq_reg.addr[`GMP_MASK_MSB:`GMP_MASK_LSB];

    // each ready while its own half is not held and no response pending
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready)
                && !s_axi_bvalid && !wr_fire;
            s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready)
                && !s_axi_bvalid && !wr_fire;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // pin value register, aliased over the whole 0x000..0x3FC window
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            value_reg <= `GMP_VALUE_RESET;
        end
        else if (wr_fire && wreq_reg.strb[0] && wreq_reg.addr <= `GMP_DATA_TOP)
        begin
            value_reg <= (value_reg & ~(wr_mask & dir_reg))
                | (wreq_reg.data[7:0] & wr_mask & dir_reg);
        end
    end

    // direction register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dir_reg <= `GMP_DIR_RESET;
        end
        else if (wr_fire && wreq_reg.strb[0] && wreq_reg.addr == `GMP_DIR_OFFSET)
        begin
            dir_reg <= wreq_reg.data[7:0];
        end
    end

    // write response; identification writes are ignored but answered okay
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GMP_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            if (wreq_reg.addr <= `GMP_DATA_TOP || wreq_reg.addr == `GMP_DIR_OFFSET
                || wreq_reg.addr >= `GMP_PID1_OFFSET)
                s_axi_bresp <= `GMP_RESP_OKAY;
            else
                s_axi_bresp <= `GMP_RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    assign rd_mask = s_axi_araddr[`GMP_MASK_MSB:`GMP_MASK_LSB];

    // one mux per pin: stored value or synchronised pad level
    // inputs show up two cycles after the pad moves
    // output stored, input live
    genvar g;
    generate
        for (g = 0; g < `GMP_PIN_COUNT; g++)
        begin : g_live
            assign live_value[g] = dir_reg[g] ? value_reg[g] : pin_sync_reg[g];
        end
    endgenerate

    // build read data for the address offered
    // decoded from the live address, latched at the accepting edge
    always_comb
    begin
        rd_next.data = 32'h0000_0000;
        rd_next.resp = `GMP_RESP_OKAY;
        if (s_axi_araddr <= `GMP_DATA_TOP)
        begin
            rd_next.data[7:0] = live_value & rd_mask;
        end
        else
        begin
            unique case (s_axi_araddr)
                `GMP_DIR_OFFSET: rd_next.data[7:0] = dir_reg;
                `GMP_PID1_OFFSET: rd_next.data[7:0] = PID1_VALUE;
                `GMP_PID2_OFFSET: rd_next.data[7:0] = PID2_VALUE;
                `GMP_PID3_OFFSET: rd_next.data[7:0] = PID3_VALUE;
                `GMP_CID0_OFFSET: rd_next.data[7:0] = CID0_VALUE;
                `GMP_CID1_OFFSET: rd_next.data[7:0] = CID1_VALUE;
                `GMP_CID2_OFFSET: rd_next.data[7:0] = CID2_VALUE;
                `GMP_CID3_OFFSET: rd_next.data[7:0] = CID3_VALUE;
                // unmapped answers an error
                default: rd_next.resp = `GMP_RESP_SLVERR;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    // one read at a time; arready is a one-cycle acceptance pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `GMP_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            // answer the taken address next cycle
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_next.data;
            s_axi_rresp <= rd_next.resp;
        end
        else if (s_axi_rvalid)
        begin
            // hold until taken
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // registered copies, so pads see no decode glitches
    // drive value trails the stored value by one cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
        end
        else
        begin
            pin_out <= value_reg;
            pin_oe <= dir_reg;
        end
    end
endmodule

// ===== verif/gmp_port_monitor.sv
// concurrent checks on the masked gpio port bus and pins
`timescale 1ns/1ps
module gmp_port_monitor (
    input wire logic aclk, // bus clock
    input wire logic aresetn, // reset, low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [11:0] s_axi_araddr, // ar address
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [7:0] pin_out, // pin drive
    input wire logic [7:0] pin_oe // pin enable
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----
    // checks
    // ----
    a_resv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("reserved read bits not zero");
    a_rd_mask: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[11:10] == 2'h0
        |=> (s_axi_rdata[7:0] & ~$past(s_axi_araddr[9:2])) == 8'h00)
        else $error("masked read bit not zero");
    a_out_on_write: assert property ($changed(pin_out) |-> $past(s_axi_bvalid))
        else $error("pin drive changed without a write");
    a_oe_on_write: assert property ($changed(pin_oe) |-> $past(s_axi_bvalid))
        else $error("pin enable changed without a write");
    a_wr_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed");
endmodule
bind gmp_port gmp_port_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_out(pin_out), .pin_oe(pin_oe));

// ===== verif/gmp_axi_master.sv
// processor side bus master model
`timescale 1ns/1ps
module gmp_axi_master (
    input wire logic aclk, // bus clock
    output gmp_pkg::gmp_wreq_t wreq, // write address, data, strobes
    output logic awvalid, // aw valid
    input wire logic awready, // aw taken
    output logic wvalid, // w valid
    input wire logic wready, // w taken
    input wire logic [1:0] bresp, // write response
    input wire logic bvalid, // write answer
    output logic bready, // write answer ready
    output logic [11:0] araddr, // read address
    output logic arvalid, // ar valid
    input wire logic arready, // ar taken
    input wire gmp_pkg::gmp_rresp_t rd, // read data, response
    input wire logic rvalid, // read answer
    output logic rready // read answer ready
);
    import gmp_pkg::*;
    int slow = 0; // cycles before ready rises
    // idle bus at time zero
    initial
    begin
        wreq = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 12'h000;
        arvalid = 1'b0;
        rready = 1'b0;
    end
    // write: both halves offered, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        wreq <= '{a, d, 4'hF};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (awvalid || wvalid);
        wreq <= ~wreq; // released payload no longer shows old value
        repeat (slow) @(posedge aclk);
        bready <= 1'b1;
        do
            @(posedge aclk);
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    // read: address held until taken, then wait for answer
    task automatic rd_word(input logic [11:0] a, output gmp_rresp_t r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        repeat (slow) @(posedge aclk);
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (!rvalid);
        r = rd;
        rready <= 1'b0;
    endtask
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the masked gpio port
`timescale 1ns/1ps
`include "gmp_cfg.svh"
`define CHK(got, exp) \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
        fails++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end
module tb_top;
    import gmp_pkg::*;
    logic aclk = 1'b0; // bus clock
    logic aresetn = 1'b0; // reset, low
    gmp_wreq_t wreq; // write payload
    logic awvalid, awready, wvalid, wready, bvalid, bready; // write handshakes
    logic arvalid, arready, rvalid, rready; // read handshakes
    logic [1:0] bresp, rresp, wr_r; // responses
    logic [11:0] araddr; // read address
    logic [31:0] rdata; // read data
    logic [7:0] pin_in = 8'h00, pin_out, pin_oe; // pads
    gmp_rresp_t rr; // last read answer
    int fails = 0, checks_done = 0, cyc = 0; // counters
    int val = 0, dir = 0; // reference port state
    logic [31:0] seed = 32'hDD805EDA; // random state
    // id values stay at their arbitrary defaults, 8'h11 up to 8'h77
    gmp_port uut (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(wreq.addr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wreq.data), .s_axi_wstrb(wreq.strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
    gmp_axi_master u_mst (.aclk(aclk), .wreq(wreq), .awvalid(awvalid), .awready(awready),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rd({rdata, rresp}),
        .rvalid(rvalid), .rready(rready));
    always #10 aclk = ~aclk;
    // hang guard
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            fails++;
            results();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wdir(input logic [7:0] dd);
        u_mst.wr(`GMP_DIR_OFFSET, {24'h000000, dd}, wr_r);
        dir = int'(dd);
    endtask
    // masked data write, then pins against model
    task automatic wdat(input logic [7:0] mm, input logic [7:0] dd);
        u_mst.wr({2'h0, mm, 2'h0}, {24'h000000, dd}, wr_r);
        `CHK(wr_r, `GMP_RESP_OKAY)
        val = (val & ~(int'(mm) & dir)) | (int'(dd) & int'(mm) & dir);
        repeat (2) @(posedge aclk);
        `CHK(pin_out, 8'(val))
        `CHK(pin_oe, 8'(dir))
    endtask
    // masked data read against model
    task automatic rdat(input logic [7:0] mm);
        u_mst.rd_word({2'h0, mm, 2'h0}, rr);
        `CHK(rr, {32'(((val & dir) | (int'(pin_in) & ~dir)) & int'(mm)), 2'h0})
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        pin_in <= 8'hA5;
        repeat (3) @(posedge aclk);
        rdat(8'hFF);
        u_mst.rd_word(`GMP_DIR_OFFSET, rr);
        `CHK(rr.data, 32'h00000000)
        wdir(8'hFF);
        rdat(8'hFF);
        $display("test reset done");
        for (int i = 0; i < 7; i++)
        begin
            u_mst.wr(12'hFE4 + 12'(4 * i), 32'hFFFFFFFF, wr_r);
            `CHK(wr_r, `GMP_RESP_OKAY)
            u_mst.rd_word(12'hFE4 + 12'(4 * i), rr);
            `CHK(rr.data, 32'((i + 1) * 17))
        end
        u_mst.wr(12'h800, 32'h00000001, wr_r);
        `CHK(wr_r, `GMP_RESP_SLVERR)
        u_mst.rd_word(12'h800, rr);
        `CHK(rr, {32'h00000000, `GMP_RESP_SLVERR})
        $display("test ident done");
        for (int n = 0; n < 60; n++)
        begin
            seed = lfsr(seed);
            u_mst.slow = int'(seed[1:0]);
            pin_in <= seed[15:8];
            if (seed[4:2] == 3'h0)
                wdir(seed[23:16]);
            wdat(seed[31:24], seed[23:16] ^ seed[7:0]);
            rdat(seed[12:5]);
        end
        $display("test random done");
        results();
    end
endmodule
